// >>> mbr_defs.vh
// Notes on behaviour
// - stop bit zero drops query, no reply
// - parity mismatch drops query, no reply
// - crc mismatch drops query silently
// - frame over 256 bytes is dropped
// - broadcast executes but never replies
// - foreign station address is ignored silently
// - exception reply: address, function, code, crc
// - exception function field is query function plus 80h
// - bad function or subfunction gives 01h/88h
// - address out of range gives 02h/88h
// - bad count, byte count, length gives 03h/8Ch
// - tool port busy gives 04h/89h
// - memory busy or alarm gives 04h/8Ah
// - written value out of range gives 04h/8Ch
// - execution disabled gives 04h/8Dh
// - slave error mode 0 sends normal reply
// - read returns up to 125 words
// - read words go out in ascending order
// - crc starts FFFFh, reflected poly A001h
// - station address 0 means broadcast
// - only functions 03h 06h 08h 10h 17h
`ifndef MBR_DEFS_VH
`define MBR_DEFS_VH

// ----------------------------------------------------------------
// crc
// ----------------------------------------------------------------
`define MBR_CRC_INIT   16'hffff
`define MBR_CRC_POLY   16'ha001
`define MBR_CRC_GOOD   16'h0000
`define MBR_CRC_BITS   4'h8

// ----------------------------------------------------------------
// framing
// ----------------------------------------------------------------
`define MBR_MAX_LEN    9'h100
`define MBR_MIN_LEN    9'h004
`define MBR_HDR_BYTES  9'h00b
`define MBR_LEN_FIXED  9'h008
`define MBR_LEN_WR_MUL 9'h009
`define MBR_LEN_RW     9'h00d
`define MBR_BCAST      8'h00

// ----------------------------------------------------------------
// functions and limits
// ----------------------------------------------------------------
`define MBR_FN_RD      8'h03
`define MBR_FN_WR      8'h06
`define MBR_FN_DIAG    8'h08
`define MBR_FN_WRM     8'h10
`define MBR_FN_RW      8'h17
`define MBR_EXC_ADD    8'h80
`define MBR_SUB_ECHO   16'h0000
`define MBR_REG_LAST   17'h057ff
`define MBR_REG_END    17'h05800
`define MBR_CNT_ONE    16'h0001
`define MBR_CNT_ZERO   16'h0000
`define MBR_RD_MAX     16'h007d
`define MBR_WRM_MAX    16'h007b
`define MBR_RWW_MAX    16'h0079

// ----------------------------------------------------------------
// exception and error codes
// ----------------------------------------------------------------
`define MBR_EXC_FUNC   8'h01
`define MBR_EXC_ADDR   8'h02
`define MBR_EXC_DATA   8'h03
`define MBR_EXC_SLAVE  8'h04
`define MBR_ERR_FUNC   8'h88
`define MBR_ERR_TOOL   8'h89
`define MBR_ERR_NVM    8'h8a
`define MBR_ERR_DATA   8'h8c
`define MBR_ERR_DIS    8'h8d

// ----------------------------------------------------------------
// reply kinds
// ----------------------------------------------------------------
`define MBR_KIND_EXC   2'h0
`define MBR_KIND_ECHO  2'h1
`define MBR_KIND_READ  2'h2
`define MBR_HDR_EXC    3'h3
`define MBR_HDR_ECHO   3'h6
`define MBR_HDR_READ   3'h3

`endif

// >>> mbr_crc16.v
`timescale 1ns/1ps
`default_nettype none
`include "mbr_defs.vh"

module mbr_crc16 (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clr,
  input  wire        en,
  input  wire [7:0]  din,
  output wire [15:0] crc
);

  reg [15:0] crc_r;
  reg [15:0] crc_nxt;
  integer    i;

  // ----------------------------------------------------------------
  // one byte per cycle, eight shifts unrolled by the loop
  // ----------------------------------------------------------------
  always @* begin
    crc_nxt = crc_r ^ {8'h00, din};
    for (i = 0; i < `MBR_CRC_BITS; i = i + 1) begin
      if (crc_nxt[0]) begin
        crc_nxt = (crc_nxt >> 1) ^ `MBR_CRC_POLY;
      end else begin
        crc_nxt = crc_nxt >> 1;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n || clr) begin
      crc_r <= `MBR_CRC_INIT;
    end else if (en) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

endmodule
`default_nettype wire

// >>> mbr_resp.v
`timescale 1ns/1ps
`default_nettype none
`include "mbr_defs.vh"

module mbr_resp (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_stop_err,
  input  wire        rx_parity_err,
  input  wire        frame_end,
  input  wire [7:0]  station_addr,
  input  wire        slave_err_resp_mode,
  input  wire        cfg_port_busy,
  input  wire        internal_busy_flag,
  input  wire        nvm_alarm,
  input  wire        range_err,
  input  wire        exec_disable,
  output wire [15:0] rd_addr,
  input  wire [15:0] rd_data,
  output wire        tx_valid,
  input  wire        tx_ready,
  output wire [7:0]  tx_data,
  output wire        tx_last,
  output wire        exec_stb,
  output wire [7:0]  exec_func,
  output wire [15:0] exec_start,
  output wire [15:0] exec_count,
  output wire        err_stb,
  output wire [7:0]  err_code,
  output wire        busy
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_HDR   = 4'h1;
  localparam [3:0] S_FETCH = 4'h2;
  localparam [3:0] S_LATCH = 4'h3;
  localparam [3:0] S_DHI   = 4'h4;
  localparam [3:0] S_DLO   = 4'h5;
  localparam [3:0] S_CRCP  = 4'h6;
  localparam [3:0] S_CRCL  = 4'h7;
  localparam [3:0] S_CRCH  = 4'h8;

  reg  [3:0]  state_r;
  reg  [8:0]  len_r;
  reg         ferr_r;
  reg         perr_r;
  reg         long_r;
  reg  [87:0] q_r;
  reg  [1:0]  kind_r;
  reg  [2:0]  hdr_len_r;
  reg  [2:0]  idx_r;
  reg  [7:0]  exc_r;
  reg  [6:0]  left_r;
  reg  [7:0]  lo_r;
  reg  [15:0] rd_addr_r;
  reg  [7:0]  tx_data_r;
  reg         exec_stb_r;
  reg  [7:0]  exec_func_r;
  reg  [15:0] exec_start_r;
  reg  [15:0] exec_count_r;
  reg         err_stb_r;
  reg  [7:0]  err_code_r;
  reg  [7:0]  hdr_byte;

  wire [15:0] crc_rx;
  wire [15:0] crc_tx;
  wire [2:0]  idx_inc = idx_r + 3'h1;

  // ----------------------------------------------------------------
  // query fields
  // ----------------------------------------------------------------
  wire [7:0]  q_addr  = q_r[7:0];
  wire [7:0]  q_fn    = q_r[15:8];
  wire [15:0] q_start = {q_r[23:16], q_r[31:24]};
  wire [15:0] q_cnt   = {q_r[39:32], q_r[47:40]};
  wire [7:0]  q_bc10  = q_r[55:48];
  wire [15:0] q_wcnt  = {q_r[71:64], q_r[79:72]};
  wire [7:0]  q_bc17  = q_r[87:80];

  wire is_rd   = (q_fn == `MBR_FN_RD);
  wire is_wr   = (q_fn == `MBR_FN_WR);
  wire is_diag = (q_fn == `MBR_FN_DIAG);
  wire is_wrm  = (q_fn == `MBR_FN_WRM);
  wire is_rw   = (q_fn == `MBR_FN_RW);
  wire fn_ok   = is_rd | is_wr | is_diag | is_wrm | is_rw;
  wire writes  = is_wr | is_wrm | is_rw;

  // rx is ignored while a reply is going out: the link is half duplex
  wire rx_take  = rx_valid && (state_r == S_IDLE);
  wire decide   = frame_end && (state_r == S_IDLE) && (len_r != 9'h000);
  wire tx_fire  = tx_valid && tx_ready;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire tx_bad = ferr_r
              | perr_r
              | (crc_rx != `MBR_CRC_GOOD)
              | long_r
              | (len_r < `MBR_MIN_LEN);
  wire bcast  = (q_addr == `MBR_BCAST);
  wire mine   = (q_addr == station_addr);

  wire e01 = !fn_ok || (is_diag && (q_start != `MBR_SUB_ECHO));

  wire [15:0] cnt_eff = is_wr ? `MBR_CNT_ONE : q_cnt;
  wire [16:0] end_sum = {1'b0, q_start} + {1'b0, cnt_eff};
  wire e02 = (is_rd | is_wr | is_wrm | is_rw) &&
             (({1'b0, q_start} > `MBR_REG_LAST) || (end_sum >= `MBR_REG_END));

  wire [15:0] cnt_max = is_wrm ? `MBR_WRM_MAX : `MBR_RD_MAX;
  wire cnt_bad  = (is_rd | is_wrm | is_rw) &&
                  ((q_cnt == `MBR_CNT_ZERO) || (q_cnt > cnt_max));
  wire wcnt_bad = is_rw && ((q_wcnt == `MBR_CNT_ZERO) || (q_wcnt > `MBR_RWW_MAX));
  wire bc_bad   = (is_wrm && ({8'h00, q_bc10} != {q_cnt[14:0], 1'b0})) ||
                  (is_rw && ({8'h00, q_bc17} != {q_wcnt[14:0], 1'b0}));
  wire [8:0] exp_len = is_wrm ? (`MBR_LEN_WR_MUL + {1'b0, q_bc10}) :
                       is_rw  ? (`MBR_LEN_RW + {1'b0, q_bc17}) : `MBR_LEN_FIXED;
  wire len_bad  = (len_r != exp_len);
  wire e03      = cnt_bad | wcnt_bad | bc_bad | len_bad;

  wire s89  = cfg_port_busy;
  wire s8a  = internal_busy_flag | nvm_alarm;
  wire s8c  = range_err & writes;
  wire s8d  = exec_disable;
  wire slv  = s89 | s8a | s8c | s8d;
  wire perr = e01 | e02 | e03;

  reg [7:0] exc_sel;
  reg [7:0] err_sel;

  always @* begin
    if (e01) begin
      exc_sel = `MBR_EXC_FUNC;
      err_sel = `MBR_ERR_FUNC;
    end else if (e02) begin
      exc_sel = `MBR_EXC_ADDR;
      err_sel = `MBR_ERR_FUNC;
    end else if (e03) begin
      exc_sel = `MBR_EXC_DATA;
      err_sel = `MBR_ERR_DATA;
    end else begin
      exc_sel = `MBR_EXC_SLAVE;
      if (s89) begin
        err_sel = `MBR_ERR_TOOL;
      end else if (s8a) begin
        err_sel = `MBR_ERR_NVM;
      end else if (s8c) begin
        err_sel = `MBR_ERR_DATA;
      end else begin
        err_sel = `MBR_ERR_DIS;
      end
    end
  end

  wire accepted = decide && !tx_bad && (bcast || mine);
  wire normal   = !perr && (!slv || !slave_err_resp_mode);
  wire reply    = accepted && !bcast;
  wire [1:0] kind_sel = !normal ? `MBR_KIND_EXC :
                        (is_rd | is_rw) ? `MBR_KIND_READ : `MBR_KIND_ECHO;

  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      len_r  <= 9'h000;
      ferr_r <= 1'b0;
      perr_r <= 1'b0;
      long_r <= 1'b0;
      q_r    <= 88'h0;
    end else if (frame_end && (state_r == S_IDLE)) begin
      len_r  <= 9'h000;
      ferr_r <= 1'b0;
      perr_r <= 1'b0;
      long_r <= 1'b0;
    end else if (rx_take) begin
      if (len_r < `MBR_HDR_BYTES) begin
        q_r[{len_r[3:0], 3'b000} +: 8] <= rx_data;
      end
      if (len_r == `MBR_MAX_LEN) begin
        long_r <= 1'b1;
      end else begin
        len_r <= len_r + 9'h001;
      end
      ferr_r <= ferr_r | rx_stop_err;
      perr_r <= perr_r | rx_parity_err;
    end
  end

  // a good frame, crc included low byte first, leaves a zero remainder
  mbr_crc16 u_crc_rx (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (frame_end && (state_r == S_IDLE)),
    .en    (rx_take),
    .din   (rx_data),
    .crc   (crc_rx)
  );

  // ----------------------------------------------------------------
  // reply header bytes
  // ----------------------------------------------------------------
  always @* begin
    case (idx_inc)
      3'h0: hdr_byte = q_addr;
      3'h1: hdr_byte = (kind_r == `MBR_KIND_EXC) ? (q_fn + `MBR_EXC_ADD) : q_fn;
      3'h2: hdr_byte = (kind_r == `MBR_KIND_EXC)  ? exc_r :
                       (kind_r == `MBR_KIND_READ) ? {q_cnt[6:0], 1'b0} : q_r[23:16];
      3'h3: hdr_byte = q_r[31:24];
      3'h4: hdr_byte = q_r[39:32];
      3'h5: hdr_byte = q_r[47:40];
      default: hdr_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // reply sequencer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      state_r   <= S_IDLE;
      kind_r    <= `MBR_KIND_EXC;
      hdr_len_r <= 3'h0;
      idx_r     <= 3'h0;
      exc_r     <= 8'h00;
      left_r    <= 7'h00;
      lo_r      <= 8'h00;
      rd_addr_r <= 16'h0000;
      tx_data_r <= 8'h00;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (reply) begin
            kind_r    <= kind_sel;
            hdr_len_r <= (kind_sel == `MBR_KIND_ECHO) ? `MBR_HDR_ECHO :
                         (kind_sel == `MBR_KIND_READ) ? `MBR_HDR_READ : `MBR_HDR_EXC;
            exc_r     <= exc_sel;
            left_r    <= q_cnt[6:0];
            idx_r     <= 3'h0;
            tx_data_r <= q_addr;
            state_r   <= S_HDR;
          end
        end
        S_HDR: begin
          if (tx_ready) begin
            if (idx_inc < hdr_len_r) begin
              idx_r     <= idx_inc;
              state_r   <= S_HDR;
              tx_data_r <= hdr_byte;
            end else if (kind_r == `MBR_KIND_READ) begin
              rd_addr_r <= q_start;
              state_r   <= S_FETCH;
            end else begin
              state_r <= S_CRCP;
            end
          end
        end
        S_FETCH: begin
          state_r <= S_LATCH;
        end
        S_LATCH: begin
          tx_data_r <= rd_data[15:8];
          lo_r      <= rd_data[7:0];
          state_r   <= S_DHI;
        end
        S_DHI: begin
          if (tx_ready) begin
            tx_data_r <= lo_r;
            state_r   <= S_DLO;
          end
        end
        S_DLO: begin
          if (tx_ready) begin
            left_r <= left_r - 7'h01;
            if (left_r == 7'h01) begin
              state_r <= S_CRCP;
            end else begin
              rd_addr_r <= rd_addr_r + 16'h0001;
              state_r   <= S_FETCH;
            end
          end
        end
        S_CRCP: begin
          tx_data_r <= crc_tx[7:0];
          state_r   <= S_CRCL;
        end
        S_CRCL: begin
          if (tx_ready) begin
            tx_data_r <= crc_tx[15:8];
            state_r   <= S_CRCH;
          end
        end
        S_CRCH: begin
          if (tx_ready) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  wire tx_body = (state_r == S_HDR) || (state_r == S_DHI) || (state_r == S_DLO);

  mbr_crc16 u_crc_tx (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (state_r == S_IDLE),
    .en    (tx_fire && tx_body),
    .din   (tx_data_r),
    .crc   (crc_tx)
  );

  // ----------------------------------------------------------------
  // execution and error log strobes
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      exec_stb_r   <= 1'b0;
      exec_func_r  <= 8'h00;
      exec_start_r <= 16'h0000;
      exec_count_r <= 16'h0000;
      err_stb_r    <= 1'b0;
      err_code_r   <= 8'h00;
    end else begin
      // broadcast still executes, only the reply is held back
      exec_stb_r <= accepted && !perr && !slv;
      err_stb_r  <= accepted && (perr || slv);
      if (accepted) begin
        exec_func_r  <= q_fn;
        exec_start_r <= q_start;
        exec_count_r <= cnt_eff;
        if (perr || slv) begin
          err_code_r <= err_sel;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign tx_valid   = tx_body || (state_r == S_CRCL) || (state_r == S_CRCH);
  assign tx_last    = (state_r == S_CRCH);
  assign tx_data    = tx_data_r;
  assign rd_addr    = rd_addr_r;
  assign exec_stb   = exec_stb_r;
  assign exec_func  = exec_func_r;
  assign exec_start = exec_start_r;
  assign exec_count = exec_count_r;
  assign err_stb    = err_stb_r;
  assign err_code   = err_code_r;
  assign busy       = (state_r != S_IDLE);

endmodule
`default_nettype wire

// >>> mbr_resp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mbr_resp_assertions (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       rx_valid,
  input wire logic       rx_stop_err,
  input wire logic       rx_parity_err,
  input wire logic       frame_end,
  input wire logic [7:0] station_addr,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic       exec_stb,
  input wire logic       err_stb,
  input wire logic [7:0] err_code,
  input wire logic       busy
);
  // ------------------------------------------------------------
  // helper: a damaged byte was taken in the current frame
  // ------------------------------------------------------------
  logic bad_r;
  always @(posedge clk) begin
    if (!rst_n || (frame_end && !busy))
      bad_r <= 1'b0;
    else if (rx_valid && !busy && (rx_stop_err || rx_parity_err))
      bad_r <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_drop;
    frame_end && !busy && bad_r |=> (!exec_stb && !err_stb && !busy) [*2];
  endproperty
  a_drop: assert property (p_drop) else $error("damaged frame not dropped");
  property p_addr;
    $rose(busy) |-> tx_valid && tx_data == station_addr && station_addr != 8'h00;
  endproperty
  a_addr: assert property (p_addr) else $error("reply without own address");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte changed before taken");
  property p_last;
    tx_last |-> tx_valid && busy;
  endproperty
  a_last: assert property (p_last) else $error("last flag without byte");
  property p_end;
    tx_valid && tx_ready && tx_last |=> !busy && !tx_valid;
  endproperty
  a_end: assert property (p_end) else $error("reply runs past its check field");
  property p_idle;
    !busy |-> !tx_valid && !tx_last;
  endproperty
  a_idle: assert property (p_idle) else $error("byte offered while idle");
  property p_code;
    err_stb |-> err_code inside {8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8d};
  endproperty
  a_code: assert property (p_code) else $error("unknown error code logged");
  property p_excl;
    !(exec_stb && err_stb);
  endproperty
  a_excl: assert property (p_excl) else $error("failed query executed");
  property p_bound;
    $rose(busy) |-> ##[1:1000] !busy;
  endproperty
  a_bound: assert property (p_bound) else $error("reply never ends");
endmodule
bind mbr_resp mbr_resp_assertions chk_u (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
  .rx_stop_err(rx_stop_err), .rx_parity_err(rx_parity_err), .frame_end(frame_end),
  .station_addr(station_addr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .tx_last(tx_last), .exec_stb(exec_stb), .err_stb(err_stb), .err_code(err_code), .busy(busy));
`default_nettype wire

// >>> mbr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbr_master_model (
  input  wire logic       clk,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_stop_err,
  output logic            rx_parity_err,
  output logic            frame_end,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last
);
  logic [7:0] got_q[$];
  int         last_at;
  initial begin
    {rx_valid, rx_stop_err, rx_parity_err, frame_end} = 4'h0;
    rx_data = 8'h00;
  end
  // ------------------------------------------------------------
  // query bytes back to back, then the end-of-frame pulse
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] q[$], input int stop_at, input int par_at);
    got_q.delete();
    last_at = -1;
    foreach (q[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_stop_err = (i == stop_at);
      rx_parity_err = (i == par_at);
    end
    @(negedge clk);
    {rx_valid, rx_stop_err, rx_parity_err} = 3'h0;
    // released line shows the inverse so a stale byte cannot pass
    rx_data = ~rx_data;
    @(negedge clk);
    frame_end = 1'b1;
    @(negedge clk);
    frame_end = 1'b0;
  endtask
  // ------------------------------------------------------------
  // reply side: slow mode stalls every other cycle
  // ------------------------------------------------------------
  always @(negedge clk) tx_ready <= (slow && tx_ready === 1'b1) ? 1'b0 : 1'b1;
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      if (tx_last === 1'b1) last_at = got_q.size();
      got_q.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

// >>> modbus_slave_response_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_slave_response_logic_bench;
  logic            clk, rst_n, slow, slave_err_resp_mode;
  logic            cfg_port_busy, internal_busy_flag, nvm_alarm, range_err, exec_disable;
  logic [7:0]      station_addr;
  wire logic       rx_valid, rx_stop_err, rx_parity_err, frame_end, tx_ready;
  wire logic       tx_valid, tx_last, exec_stb, err_stb, busy;
  wire logic [7:0] rx_data, tx_data, exec_func, err_code;
  wire logic [15:0] rd_addr, rd_data, exec_start, exec_count;
  logic [7:0]      q[$], e[$];
  int              err_count, n_compared, exec_n, err_n, x0, e0;
  assign rd_data = rd_addr ^ 16'ha5c3;
  mbr_resp dut_u (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_stop_err(rx_stop_err), .rx_parity_err(rx_parity_err), .frame_end(frame_end),
    .station_addr(station_addr), .slave_err_resp_mode(slave_err_resp_mode),
    .cfg_port_busy(cfg_port_busy), .internal_busy_flag(internal_busy_flag), .nvm_alarm(nvm_alarm),
    .range_err(range_err), .exec_disable(exec_disable), .rd_addr(rd_addr), .rd_data(rd_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
    .exec_stb(exec_stb), .exec_func(exec_func), .exec_start(exec_start), .exec_count(exec_count),
    .err_stb(err_stb), .err_code(err_code), .busy(busy));
  mbr_master_model m_u (.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_stop_err(rx_stop_err), .rx_parity_err(rx_parity_err), .frame_end(frame_end),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (exec_stb === 1'b1) exec_n++;
    if (err_stb === 1'b1) err_n++;
  end
  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic add_crc(inout logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
  endtask
  task automatic run(input logic [7:0] qq[$], input int sa, input int pa, input logic [7:0] ex[$]);
    int i;
    x0 = exec_n;
    e0 = err_n;
    m_u.send(qq, sa, pa);
    for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
    if (i == 2000) begin
      err_count++;
      end_of_test();
    end
    repeat (2) @(negedge clk);
    chk("reply length", 16'(m_u.got_q.size()), 16'(ex.size()));
    foreach (ex[k]) chk("reply byte", {8'h00, m_u.got_q[k]}, {8'h00, ex[k]});
    if (ex.size() > 0) chk("last flag", 16'(m_u.last_at), 16'(ex.size() - 1));
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic rd_case(input logic [15:0] st, input logic [15:0] ct, input logic sl);
    logic [15:0] a, v;
    slow = sl;
    q = '{8'h01, 8'h03, st[15:8], st[7:0], ct[15:8], ct[7:0]};
    add_crc(q);
    e = '{8'h01, 8'h03, 8'(ct * 2)};
    for (a = st; a < st + ct; a++) begin
      v = a ^ 16'ha5c3;
      e.push_back(v[15:8]);
      e.push_back(v[7:0]);
    end
    add_crc(e);
    run(q, -1, -1, e);
    chk("read exec", 16'(exec_n - x0), 16'h0001);
    chk("read start", exec_start, st);
    chk("read count", exec_count, ct);
    slow = 1'b0;
  endtask
  task automatic exc_case(input logic [7:0] fn, input logic [15:0] st, input logic [15:0] ct,
                          input logic [4:0] fl, input logic [7:0] ec, input logic [7:0] er);
    {cfg_port_busy, internal_busy_flag, nvm_alarm, range_err, exec_disable} = fl;
    q = '{8'h01, fn, st[15:8], st[7:0], ct[15:8], ct[7:0]};
    if (fn == 8'h10) q = {q, 8'h03, 8'h00, 8'h00, 8'h00};
    if (fn == 8'h17) q = {q, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
    add_crc(q);
    e = '{8'h01, fn | 8'h80, ec};
    if (slave_err_resp_mode == 1'b0) e = q[0:5];
    add_crc(e);
    run(q, -1, -1, e);
    chk("error code", {8'h00, err_code}, {8'h00, er});
    chk("error strobes", 16'(err_n - e0), 16'h0001);
    chk("exec strobes", 16'(exec_n - x0), 16'h0000);
    {cfg_port_busy, internal_busy_flag, nvm_alarm, range_err, exec_disable} = 5'h00;
  endtask
  task automatic sc_drop;
    int k;
    for (k = 0; k < 5; k++) begin
      q = '{(k == 3) ? 8'h02 : 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
      if (k == 4) repeat (249) q.push_back(8'h00);
      add_crc(q);
      if (k == 2) q[7] = ~q[7];
      e.delete();
      run(q, (k == 0) ? 3 : -1, (k == 1) ? 5 : -1, e);
      chk("drop strobes", 16'(exec_n - x0 + err_n - e0), 16'h0000);
    end
  endtask
  task automatic sc_bcast;
    q = '{8'h00, 8'h06, 8'h00, 8'h10, 8'h12, 8'h34};
    add_crc(q);
    e.delete();
    run(q, -1, -1, e);
    chk("bcast exec", 16'(exec_n - x0), 16'h0001);
    chk("bcast func", {8'h00, exec_func}, 16'h0006);
  endtask
  task automatic sc_norm;
    q = '{8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
    add_crc(q);
    e = q[0:5];
    add_crc(e);
    run(q, -1, -1, e);
    chk("write multi exec", 16'(exec_n - x0), 16'h0001);
    q = '{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
    add_crc(q);
    e = q;
    run(q, -1, -1, e);
    chk("diag exec", 16'(exec_n - x0), 16'h0001);
    q = '{8'h01, 8'h17, 8'h00, 8'h30, 8'h00, 8'h01, 8'h00, 8'h40, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
    add_crc(q);
    // register model: value is address xor a5c3
    e = '{8'h01, 8'h17, 8'h02, 8'ha5, 8'hf3};
    add_crc(e);
    run(q, -1, -1, e);
    chk("read write start", exec_start, 16'h0030);
  endtask
  task automatic sc_exc;
    exc_case(8'h05, 16'h0000, 16'h0001, 5'h00, 8'h01, 8'h88);
    exc_case(8'h08, 16'h0001, 16'h0000, 5'h00, 8'h01, 8'h88);
    exc_case(8'h03, 16'h5800, 16'h0001, 5'h00, 8'h02, 8'h88);
    exc_case(8'h03, 16'h57ff, 16'h0001, 5'h00, 8'h02, 8'h88);
    exc_case(8'h03, 16'h0000, 16'h0000, 5'h00, 8'h03, 8'h8c);
    exc_case(8'h03, 16'h0000, 16'h007e, 5'h00, 8'h03, 8'h8c);
    exc_case(8'h10, 16'h0000, 16'h0001, 5'h00, 8'h03, 8'h8c);
    exc_case(8'h17, 16'h0000, 16'h0000, 5'h00, 8'h03, 8'h8c);
    exc_case(8'h06, 16'h0010, 16'h1234, 5'h10, 8'h04, 8'h89);
    exc_case(8'h06, 16'h0010, 16'h1234, 5'h08, 8'h04, 8'h8a);
    exc_case(8'h06, 16'h0010, 16'h1234, 5'h04, 8'h04, 8'h8a);
    exc_case(8'h06, 16'h0010, 16'h1234, 5'h02, 8'h04, 8'h8c);
    exc_case(8'h06, 16'h0010, 16'h1234, 5'h01, 8'h04, 8'h8d);
    slave_err_resp_mode = 1'b0;
    exc_case(8'h06, 16'h0010, 16'h1234, 5'h01, 8'h04, 8'h8d);
    slave_err_resp_mode = 1'b1;
  endtask
  initial begin
    {rst_n, slow, cfg_port_busy, internal_busy_flag, nvm_alarm, range_err, exec_disable} = 7'h00;
    slave_err_resp_mode = 1'b1;
    station_addr = 8'h01;
    {err_count, n_compared, exec_n, err_n} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rd_case(16'h0480, 16'h0002, 1'b1);
    rd_case(16'h0000, 16'h007d, 1'b0);
    sc_drop();
    sc_bcast();
    sc_norm();
    sc_exc();
    end_of_test();
  end
endmodule
`default_nettype wire
